// >>> design/glue_params.svh
// Offsets, field positions, reset values and counts for the card UART glue block
`ifndef GLUE_PARAMS_SVH
`define GLUE_PARAMS_SVH

// Subsystem address map (9-bit subsystem address)
`define SUB_ATTR_LAST 9'h107
`define SUB_CTRL_ADDR 9'h110
`define SUB_DIVISOR_ADDR 9'h120
`define SUB_MCR_WR_ADDR 9'h130
`define SUB_FCR_RD_ADDR 9'h132
`define SUB_MCR_RD_ADDR 9'h134
`define SUB_BYPASS_ADDR 9'h140

// Host UART register indexes
`define UART_FCR_INDEX 3'h2
`define UART_MCR_INDEX 3'h4

// Subsystem control register: reset value and bit positions
`define CTRL_RESET 8'h22
`define CTRL_COM_LO 0
`define CTRL_COM_HI 1
`define CTRL_STS_EN 2
`define CTRL_ADDR_MODE 3
`define CTRL_READY 4
`define CTRL_MEM_CARD 5
`define CTRL_IRQ_CLR 6
`define CTRL_BYPASS 7

// FIFO control and modem control fields
`define FCR_AUTO_RTS 4
`define FCR_DEEP 5
`define FCR_RD_ONES 8'h06
`define MCR_AUTO_CTS 5

// Receive trigger levels, 64-byte mode and 16-byte mode
`define TRIG_DEEP_0 6'h01
`define TRIG_DEEP_1 6'h10
`define TRIG_DEEP_2 6'h20
`define TRIG_DEEP_3 6'h38
`define TRIG_STD_0 6'h01
`define TRIG_STD_1 6'h04
`define TRIG_STD_2 6'h08
`define TRIG_STD_3 6'h0e

// Divider, counted in crystal half-cycles
`define DIV_STOP 6'h00
`define DIV_SHORT_MIN 6'h04
`define DIV_LONG_MIN 6'h10
`define LOW_SHORT 6'h02
`define LOW_LONG 6'h08

`endif

// >>> design/glue_pkg.sv
// Types carried between the card UART glue block and its neighbours
package glue_pkg;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic card_enable_low_n;
    logic card_enable_high_n;
    logic reg_select_n;
    logic host_io_read_strobe_n;
    logic host_io_write_strobe_n;
    logic attr_write_n;
    logic attr_read_n;
  } host_bus_type;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic write_n;
    logic read_n;
  } sub_bus_type;

  typedef struct packed {
    logic divided_arbitration_clock;
    logic crystal_input_clock;
    logic extend;
    logic uart_interrupt;
  } misc_pins_type;

  typedef struct packed {
    logic we;
    logic host_side;
    logic [8:0] addr;
    logic [7:0] data;
  } attr_write_type;

  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [2:0] uart_register_index;
  } uart_access_type;

  typedef struct packed {
    logic deep;
    logic auto_rts;
    logic [5:0] trigger;
  } fifo_mode_type;

endpackage

// >>> design/pc_card_uart_glue_control.sv
// Card UART glue: arbitration, handshake flags, UART select, control regs, clock divider
`timescale 1ns/100ps
`include "glue_params.svh"

// Function
// R01: Same-address simultaneous writes: host write completes, subsystem write is dropped.
// R02: Host attribute write raises subsystem flag; writing one to control bit 6 clears it.
// R03: Subsystem attribute write asserts host status-change output while control bit 2 set.
// R04: Any host attribute read deasserts the host status-change output.
// R05: Both handshake flags change only on divided arbitration clock edges.
// R06: Coincident set and clear: set wins; later clear takes effect next edge.
// R07: Address mode selects UART from fixed bits plus two COM-dependent bits.
// R08: Otherwise either card enable with register select picks the UART.
// R09: UART access needs I/O read or write strobe; low address bits pick register.
// R10: Extend and FIFO-control bits 5,4 set FIFO depth and auto RTS.
// R11: Deep mode maps FIFO-control bits 7:6 to triggers 1, 16, 32, 56.
// R12: Modem-control bit 5 is subsystem-written only; subsystem reads whole register back.
// R13: Subsystem FIFO-control read: bits 1,2 high; bits 4,5 low only when active.
// R14: Control bits 1:0 choose COM port; COM2 after reset.
// R15: Control bit 3 enables address mode, bit 2 status enable; both reset clear.
// R16: Control bits 5:4 reset to 10; ready and I/O card handover by subsystem.
// R17: Control bit 7 enables serial bypass and clears on reset.
// R18: Six-bit write-only divisor; each write resets UART and divider.
// R19: Divisor 0 to 31.5 in half steps drives the UART clock output.
// R20: Low time one or 1.5 crystal cycles below 8, four or 4.5 above.
// R21: Value 0 holds clock high; 1 to 3 divide by one; others divide by value/2.
// R22: Bypass: subsystem writes feed receive FIFO, reads pop transmit FIFO; line errors masked.
// R23: Interrupt-clear control bit reads zero; writing zero does nothing.
module pc_card_uart_glue_control (
  input wire logic core_clk,
  input wire logic rst,
  input wire glue_pkg::host_bus_type host_bus,
  input wire glue_pkg::sub_bus_type sub_bus,
  input wire logic divided_arbitration_clock,
  input wire logic crystal_input_clock,
  input wire logic extend,
  input wire logic uart_interrupt,
  input wire logic [7:0] tx_fifo_data,
  output logic [7:0] sub_read_data,
  output glue_pkg::attr_write_type attr_write,
  output logic sub_interrupt,
  output logic host_status_change_n,
  output logic host_ready_interrupt_line,
  output glue_pkg::uart_access_type uart_access,
  output glue_pkg::fifo_mode_type fifo_mode,
  output logic auto_cts_enable,
  output logic serial_bypass,
  output logic rx_fifo_push,
  output logic [7:0] rx_fifo_data,
  output logic tx_fifo_pop,
  output logic uart_reset,
  output logic uart_clock_output
);
  import glue_pkg::*;

  host_bus_type host_s1, host_s2, host_p;
  sub_bus_type sub_s1, sub_s2, sub_p;
  misc_pins_type misc_s1, misc_s2, misc_p;
  misc_pins_type misc_in;

  logic host_attr_wr_ev, host_attr_rd_ev, host_io_wr_ev, host_io_rd_ev;
  logic sub_wr_ev, sub_rd_ev, sub_attr_wr, arb_edge, xin_edge, sel_now;

  logic [7:0] ctrl_r, ctrl_nxt, fcr_r, fcr_nxt, mcr_r, mcr_nxt;
  logic [5:0] div_r, div_nxt;
  logic [7:0] rdata_r, rdata_nxt, rx_data_r, rx_data_nxt;
  logic uart_reset_r, uart_reset_nxt, rx_push_r, rx_push_nxt, tx_pop_r, tx_pop_nxt;
  logic irq_clear;

  attr_write_type attr_r, attr_nxt;
  logic pend_r, pend_nxt;
  logic [8:0] pend_addr_r, pend_addr_nxt;
  logic [7:0] pend_data_r, pend_data_nxt;

  logic irq_r, irq_nxt, sts_r, sts_nxt;
  logic irq_set_q, irq_set_nxt, irq_clr_q, irq_clr_nxt;
  logic sts_set_q, sts_set_nxt, sts_clr_q, sts_clr_nxt;

  uart_access_type uacc_r, uacc_nxt;
  fifo_mode_type fmode_r, fmode_nxt;
  logic cts_r, cts_nxt, bypass_r, bypass_nxt, ready_r, ready_nxt;

  logic [5:0] hc_r, hc_nxt, low_len;
  logic uclk_r, uclk_nxt;

  // Host UART select, address mode or card-enable mode
  function automatic logic uart_select(input host_bus_type h, input logic [7:0] ctrl);
    logic fixed_ok;
    fixed_ok = h.addr[9] & h.addr[7] & h.addr[6] & h.addr[5] & h.addr[3];
    if (ctrl[`CTRL_ADDR_MODE]) // R07
      uart_select = fixed_ok & (h.addr[8] == ~ctrl[`CTRL_COM_HI])
                    & (h.addr[4] == ~ctrl[`CTRL_COM_LO]);
    else // R08
      uart_select = (~h.card_enable_low_n | ~h.card_enable_high_n) & ~h.reg_select_n;
  endfunction

  // Receive trigger level for the current depth
  function automatic logic [5:0] trigger_level(input logic deep, input logic [1:0] code);
    unique case (code)
      2'b00: trigger_level = deep ? `TRIG_DEEP_0 : `TRIG_STD_0;
      2'b01: trigger_level = deep ? `TRIG_DEEP_1 : `TRIG_STD_1;
      2'b10: trigger_level = deep ? `TRIG_DEEP_2 : `TRIG_STD_2;
      2'b11: trigger_level = deep ? `TRIG_DEEP_3 : `TRIG_STD_3;
    endcase
  endfunction

  // Host, subsystem and misc pins are foreign to core_clk, so all pass two flops; the third stage feeds edges
  assign misc_in = '{divided_arbitration_clock, crystal_input_clock, extend, uart_interrupt};

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      host_s1 <= '1;
      host_s2 <= '1;
      host_p <= '1;
      sub_s1 <= '1;
      sub_s2 <= '1;
      sub_p <= '1;
      misc_s1 <= '0;
      misc_s2 <= '0;
      misc_p <= '0;
    end
    else
    begin
      host_s1 <= host_bus;
      host_s2 <= host_s1;
      host_p <= host_s2;
      sub_s1 <= sub_bus;
      sub_s2 <= sub_s1;
      sub_p <= sub_s2;
      misc_s1 <= misc_in;
      misc_s2 <= misc_s1;
      misc_p <= misc_s2;
    end
  end

  // Strobe fronts, taken once per access from the synchronised copies
  always_comb
  begin
    host_attr_wr_ev = ~host_s2.attr_write_n & host_p.attr_write_n;
    host_attr_rd_ev = ~host_s2.attr_read_n & host_p.attr_read_n;
    sel_now = uart_select(host_s2, ctrl_r) & ~ctrl_r[`CTRL_MEM_CARD];
    host_io_wr_ev = sel_now & ~host_s2.host_io_write_strobe_n
                    & host_p.host_io_write_strobe_n; // R09
    host_io_rd_ev = sel_now & ~host_s2.host_io_read_strobe_n
                    & host_p.host_io_read_strobe_n; // R09
    sub_wr_ev = ~sub_s2.write_n & sub_p.write_n;
    sub_rd_ev = ~sub_s2.read_n & sub_p.read_n;
    sub_attr_wr = sub_wr_ev & (sub_s2.addr <= `SUB_ATTR_LAST);
    arb_edge = misc_s2.divided_arbitration_clock & ~misc_p.divided_arbitration_clock;
    xin_edge = misc_s2.crystal_input_clock ^ misc_p.crystal_input_clock;
  end

  // Control, divisor, FIFO-control and modem-control registers and subsystem reads
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    div_nxt = div_r;
    fcr_nxt = fcr_r;
    mcr_nxt = mcr_r;
    rdata_nxt = rdata_r;
    rx_data_nxt = rx_data_r;
    uart_reset_nxt = 1'b0;
    rx_push_nxt = 1'b0;
    tx_pop_nxt = 1'b0;
    irq_clear = 1'b0;
    if (sub_wr_ev)
    begin
      unique case (sub_s2.addr)
        `SUB_CTRL_ADDR:
        begin
          // Bit 6 is never stored, so it reads zero and a zero write is inert
          ctrl_nxt = {sub_s2.wdata[7], 1'b0, sub_s2.wdata[5:0]}; // R14 R15 R16 R17 R23
          irq_clear = sub_s2.wdata[`CTRL_IRQ_CLR]; // R02
        end
        `SUB_DIVISOR_ADDR:
        begin
          div_nxt = sub_s2.wdata[5:0]; // R18
          uart_reset_nxt = 1'b1; // R18
        end
        `SUB_MCR_WR_ADDR: mcr_nxt[`MCR_AUTO_CTS] = sub_s2.wdata[`MCR_AUTO_CTS]; // R12
        `SUB_BYPASS_ADDR:
        begin
          if (ctrl_r[`CTRL_BYPASS])
          begin
            rx_push_nxt = 1'b1; // R22
            rx_data_nxt = sub_s2.wdata;
          end
        end
        default: ;
      endcase
    end
    if (host_io_wr_ev && host_s2.addr[2:0] == `UART_FCR_INDEX)
      fcr_nxt = host_s2.wdata;
    // Host cannot touch bit 5; it keeps whatever the subsystem left there
    if (host_io_wr_ev && host_s2.addr[2:0] == `UART_MCR_INDEX)
      mcr_nxt = {host_s2.wdata[7:6], mcr_nxt[`MCR_AUTO_CTS], host_s2.wdata[4:0]}; // R12
    if (sub_rd_ev)
    begin
      unique case (sub_s2.addr)
        `SUB_CTRL_ADDR: rdata_nxt = ctrl_r; // R23
        `SUB_MCR_RD_ADDR: rdata_nxt = mcr_r; // R12
        `SUB_FCR_RD_ADDR:
        begin
          rdata_nxt = fcr_r | `FCR_RD_ONES; // R13
          rdata_nxt[`FCR_AUTO_RTS] = ~(fcr_r[`FCR_AUTO_RTS] & ~misc_s2.extend); // R13
          rdata_nxt[`FCR_DEEP] = ~(fcr_r[`FCR_DEEP] & ~misc_s2.extend); // R13
        end
        `SUB_BYPASS_ADDR:
        begin
          rdata_nxt = ctrl_r[`CTRL_BYPASS] ? tx_fifo_data : 8'h00;
          tx_pop_nxt = ctrl_r[`CTRL_BYPASS]; // R22
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_r <= `CTRL_RESET; // R14 R15 R16 R17
      div_r <= 6'h00;
      fcr_r <= 8'h00;
      mcr_r <= 8'h00;
      rdata_r <= 8'h00;
      rx_data_r <= 8'h00;
      uart_reset_r <= 1'b0;
      rx_push_r <= 1'b0;
      tx_pop_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
      fcr_r <= fcr_nxt;
      mcr_r <= mcr_nxt;
      rdata_r <= rdata_nxt;
      rx_data_r <= rx_data_nxt;
      uart_reset_r <= uart_reset_nxt;
      rx_push_r <= rx_push_nxt;
      tx_pop_r <= tx_pop_nxt;
    end
  end

  // Attribute write port; a subsystem write losing the cycle to a host write at another address waits one cycle
  always_comb
  begin
    attr_nxt = attr_r;
    attr_nxt.we = 1'b0;
    pend_nxt = 1'b0;
    pend_addr_nxt = pend_addr_r;
    pend_data_nxt = pend_data_r;
    if (host_attr_wr_ev)
    begin
      attr_nxt = '{1'b1, 1'b1, host_s2.addr[9:1], host_s2.wdata};
      // Same-address subsystem write is dropped, others are deferred
      if (sub_attr_wr && sub_s2.addr != host_s2.addr[9:1]) // R01
      begin
        pend_nxt = 1'b1;
        pend_addr_nxt = sub_s2.addr;
        pend_data_nxt = sub_s2.wdata;
      end
    end
    else if (pend_r)
      attr_nxt = '{1'b1, 1'b0, pend_addr_r, pend_data_r};
    else if (sub_attr_wr)
      attr_nxt = '{1'b1, 1'b0, sub_s2.addr, sub_s2.wdata};
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      attr_r <= '0;
      pend_r <= 1'b0;
      pend_addr_r <= 9'h000;
      pend_data_r <= 8'h00;
    end
    else
    begin
      attr_r <= attr_nxt;
      pend_r <= pend_nxt;
      pend_addr_r <= pend_addr_nxt;
      pend_data_r <= pend_data_nxt;
    end
  end

  // Handshake flags: requests collect between arbitration edges so none glitch out
  always_comb
  begin
    irq_set_nxt = (irq_set_q & ~irq_clear) | host_attr_wr_ev; // R02 R06
    irq_clr_nxt = irq_clr_q | irq_clear; // R02
    sts_set_nxt = (sts_set_q & ~host_attr_rd_ev) | (sub_attr_wr & ctrl_r[`CTRL_STS_EN]); // R03
    sts_clr_nxt = sts_clr_q | host_attr_rd_ev; // R04
    irq_nxt = irq_r;
    sts_nxt = sts_r;
    if (arb_edge) // R05
    begin
      // A later clear cancels a pending set; a same-cycle set wins
      irq_nxt = irq_set_nxt ? 1'b1 : (irq_clr_nxt ? 1'b0 : irq_r); // R06
      sts_nxt = sts_set_nxt ? 1'b1 : (sts_clr_nxt ? 1'b0 : sts_r); // R06
      irq_set_nxt = 1'b0;
      irq_clr_nxt = 1'b0;
      sts_set_nxt = 1'b0;
      sts_clr_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_r <= 1'b0;
      sts_r <= 1'b0;
      irq_set_q <= 1'b0;
      irq_clr_q <= 1'b0;
      sts_set_q <= 1'b0;
      sts_clr_q <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt;
      sts_r <= sts_nxt;
      irq_set_q <= irq_set_nxt;
      irq_clr_q <= irq_clr_nxt;
      sts_set_q <= sts_set_nxt;
      sts_clr_q <= sts_clr_nxt;
    end
  end

  // UART access decode, FIFO mode and card-state outputs
  always_comb
  begin
    uacc_nxt = '{sel_now, host_io_rd_ev, host_io_wr_ev, host_s2.addr[2:0]}; // R09
    fmode_nxt.deep = fcr_r[`FCR_DEEP] & ~misc_s2.extend; // R10
    fmode_nxt.auto_rts = fcr_r[`FCR_AUTO_RTS] & ~misc_s2.extend; // R10
    fmode_nxt.trigger = trigger_level(fmode_nxt.deep, fcr_r[7:6]); // R11
    cts_nxt = mcr_r[`MCR_AUTO_CTS]; // R12
    bypass_nxt = ctrl_r[`CTRL_BYPASS]; // R22
    // Busy/ready while a memory card, UART interrupt once an I/O card
    ready_nxt = ctrl_r[`CTRL_MEM_CARD] ? ctrl_r[`CTRL_READY] : misc_s2.uart_interrupt; // R16
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      uacc_r <= '0;
      fmode_r <= '{1'b0, 1'b0, `TRIG_STD_0};
      cts_r <= 1'b0;
      bypass_r <= 1'b0;
      ready_r <= 1'b0;
    end
    else
    begin
      uacc_r <= uacc_nxt;
      fmode_r <= fmode_nxt;
      cts_r <= cts_nxt;
      bypass_r <= bypass_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Divide-by-n-and-a-half: both crystal edges are counted, so the register is half-cycles
  // Crystal is sampled, so it must run well below half of core_clk
  always_comb
  begin
    low_len = (div_r >= `DIV_LONG_MIN) ? `LOW_LONG + {5'h00, div_r[0]}
                                       : `LOW_SHORT + {5'h00, div_r[0]}; // R20
    hc_nxt = hc_r;
    uclk_nxt = uclk_r;
    if (uart_reset_nxt) // R18
    begin
      hc_nxt = 6'h00;
      uclk_nxt = 1'b1;
    end
    else if (div_r == `DIV_STOP) // R21
      uclk_nxt = 1'b1;
    else if (div_r < `DIV_SHORT_MIN) // R21
      uclk_nxt = misc_s2.crystal_input_clock;
    else if (xin_edge) // R19
    begin
      hc_nxt = (hc_r >= div_r - 6'h01) ? 6'h00 : hc_r + 6'h01;
      uclk_nxt = hc_nxt >= low_len; // R20
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hc_r <= 6'h00;
      uclk_r <= 1'b1;
    end
    else
    begin
      hc_r <= hc_nxt;
      uclk_r <= uclk_nxt;
    end
  end

  // Outputs straight from flops
  assign sub_read_data = rdata_r;
  assign attr_write = attr_r;
  assign sub_interrupt = irq_r;
  assign host_status_change_n = ~sts_r;
  assign host_ready_interrupt_line = ready_r;
  assign uart_access = uacc_r;
  assign fifo_mode = fmode_r;
  assign auto_cts_enable = cts_r;
  assign serial_bypass = bypass_r;
  assign rx_fifo_push = rx_push_r;
  assign rx_fifo_data = rx_data_r;
  assign tx_fifo_pop = tx_pop_r;
  assign uart_reset = uart_reset_r;
  assign uart_clock_output = uclk_r;

endmodule // pc_card_uart_glue_control

// >>> test/glue_chk.sv
// Port checker for the card UART glue block
`timescale 1ns/100ps
module glue_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic divided_arbitration_clock,
  input wire logic extend,
  input wire glue_pkg::host_bus_type host_bus,
  input wire glue_pkg::sub_bus_type sub_bus,
  input wire glue_pkg::attr_write_type attr_write,
  input wire logic sub_interrupt,
  input wire logic host_status_change_n,
  input wire glue_pkg::uart_access_type uart_access,
  input wire glue_pkg::fifo_mode_type fifo_mode,
  input wire logic serial_bypass,
  input wire logic rx_fifo_push,
  input wire logic tx_fifo_pop,
  input wire logic uart_reset,
  input wire logic uart_clock_output
);
  import glue_pkg::*;
  logic arb_r, arb_nxt;
  logic [3:0] age_r, age_nxt;

  // Cycles since the arbitration pin rose; flags may only move just after
  always_comb
  begin
    arb_nxt = divided_arbitration_clock;
    age_nxt = (divided_arbitration_clock && !arb_r) ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
  end

  // Saturated on reset so that a flag change without a rise is caught
  always_ff @(posedge core_clk)
  begin
    arb_r <= rst ? 1'b0 : arb_nxt;
    age_r <= rst ? 4'hf : age_nxt;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_rst_idle;
    disable iff (1'b0) rst |=> !serial_bypass && host_status_change_n && uart_clock_output;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
  property p_arb_sync;
    $changed(sub_interrupt) || $changed(host_status_change_n) |-> age_r <= 4'h5;
  endproperty
  a_arb_sync: assert property (p_arb_sync) else $error("flag moved off arbitration edge");
  property p_irq_set;
    attr_write.we && attr_write.host_side |-> ##[1:26] sub_interrupt;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("host write did not raise flag");
  property p_sts_clr;
    $fell(host_bus.attr_read_n) && sub_bus.write_n |-> ##[1:28] host_status_change_n;
  endproperty
  a_sts_clr: assert property (p_sts_clr) else $error("host read left status asserted");
  property p_acc;
    uart_access.wr |-> !$past(host_bus.host_io_write_strobe_n, 2) ##1 !uart_access.wr;
  endproperty
  a_acc: assert property (p_acc) else $error("write pulse without strobe");
  property p_trig;
    fifo_mode.deep |-> fifo_mode.trigger inside {6'h01, 6'h10, 6'h20, 6'h38};
  endproperty
  a_trig: assert property (p_trig) else $error("bad deep trigger level");
  property p_ext;
    extend [*6] |-> !fifo_mode.deep && !fifo_mode.auto_rts;
  endproperty
  a_ext: assert property (p_ext) else $error("extend did not force normal mode");
  property p_byp;
    rx_fifo_push || tx_fifo_pop |-> serial_bypass;
  endproperty
  a_byp: assert property (p_byp) else $error("fifo access outside bypass");
  property p_divw;
    $fell(sub_bus.write_n) && sub_bus.addr == 9'h120 |-> ##[1:5] uart_reset;
  endproperty
  a_divw: assert property (p_divw) else $error("divisor write gave no reset");

  c_irq: cover property ($rose(sub_interrupt));
  c_sts: cover property ($fell(host_status_change_n));
  c_push: cover property (rx_fifo_push);
endmodule // glue_chk

bind pc_card_uart_glue_control glue_chk i_glue_chk (.core_clk, .rst, .divided_arbitration_clock,
  .extend, .host_bus, .sub_bus, .attr_write, .sub_interrupt, .host_status_change_n, .uart_access,
  .fifo_mode, .serial_bypass, .rx_fifo_push, .tx_fifo_pop, .uart_reset, .uart_clock_output);

// >>> test/glue_far_model.sv
// Far side model: crystal and arbitration clocks, transmit FIFO head
`timescale 1ns/100ps
module glue_far_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tx_fifo_pop,
  output logic crystal_input_clock,
  output logic divided_arbitration_clock,
  output logic [7:0] tx_fifo_data
);
  logic [3:0] tick_r = 4'h0;

  // Crystal half period 4 cycles, slow enough for sampling; arbitration period 16
  always @(negedge core_clk)
  begin
    tick_r <= rst ? 4'h0 : tick_r + 4'h1;
  end
  assign crystal_input_clock = tick_r[2];
  assign divided_arbitration_clock = tick_r[3];

  // Head of the transmit FIFO moves on at each pop
  always @(posedge core_clk)
  begin
    tx_fifo_data <= rst ? 8'hc0 : tx_fifo_data + {7'h0, tx_fifo_pop};
  end
endmodule // glue_far_model

// >>> test/pc_card_uart_glue_control_test.sv
// Self-checking bench for the card UART glue block
`timescale 1ns/100ps
module pc_card_uart_glue_control_test;
  import glue_pkg::*;
  localparam logic [3:0] ior = 4'h7, iow = 4'hb, aw = 4'hd, ar = 4'he;
  localparam logic [1:0] sw = 2'b01, sr = 2'b10;
  logic core_clk = 1'b0, rst = 1'b1, extend = 1'b0, uart_interrupt = 1'b0;
  logic divided_arbitration_clock, crystal_input_clock, sub_interrupt, host_status_change_n;
  logic host_ready_interrupt_line, auto_cts_enable, serial_bypass, rx_fifo_push, tx_fifo_pop;
  logic uart_reset, uart_clock_output;
  logic [7:0] tx_fifo_data, sub_read_data, rx_fifo_data;
  host_bus_type host_bus = {10'h0, 8'h0, 3'h7, 4'hf};
  sub_bus_type sub_bus = {9'h0, 8'h0, 2'h3};
  attr_write_type attr_write;
  uart_access_type uart_access;
  fifo_mode_type fifo_mode;
  logic [2:0] ce = 3'h7, lidx;
  logic [15:0] q[$];
  logic [7:0] pq[$];
  int fails, n_tests, n_subw, n_acc, n_res, lo_c, lo_w, per_c, per_w, a0, lo, per;
  integer seed = 32'h0896;
  logic [2:0] idx;
  logic [7:0] d;
  logic [5:0] trig [4] = '{6'h01, 6'h10, 6'h20, 6'h38};
  logic [9:0] base [4] = '{10'h3f8, 10'h2f8, 10'h3e8, 10'h2e8};
  logic [1:0] com [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
  logic [5:0] dv [8] = '{6'h00, 6'h01, 6'h03, 6'h08, 6'h09, 6'h10, 6'h11, 6'h3f};

  always #50 core_clk = ~core_clk;

  glue_far_model i_glue_far_model (.core_clk, .rst, .tx_fifo_pop, .crystal_input_clock,
    .divided_arbitration_clock, .tx_fifo_data);
  pc_card_uart_glue_control i_pc_card_uart_glue_control (.core_clk, .rst, .host_bus, .sub_bus,
    .divided_arbitration_clock, .crystal_input_clock, .extend, .uart_interrupt, .tx_fifo_data,
    .sub_read_data, .attr_write, .sub_interrupt, .host_status_change_n,
    .host_ready_interrupt_line, .uart_access, .fifo_mode, .auto_cts_enable, .serial_bypass,
    .rx_fifo_push, .rx_fifo_data, .tx_fifo_pop, .uart_reset, .uart_clock_output);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Strobes held 4 cycles and idle 3, above the two-cycle minimum either way
  task automatic h(input logic [9:0] a, input logic [7:0] dt, input logic [3:0] k);
    host_bus = {a, dt, ce, k};
    w(4);
    host_bus[3:0] = 4'hf;
    w(3);
  endtask

  task automatic s(input logic [8:0] a, input logic [7:0] dt, input logic [1:0] k);
    sub_bus = {a, dt, k};
    w(4);
    sub_bus[1:0] = 2'h3;
    w(3);
  endtask

  task automatic r(input logic [8:0] a, input logic [7:0] e, input logic [7:0] m);
    q.push_back({m, e});
    s(a, 8'h00, sr);
  endtask

  task end_of_test;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Read data stands until the next read, so it is judged as the strobe ends
  always @(posedge sub_bus.read_n)
  begin
    if (q.size())
    begin
      a0 = q.pop_front();
      chk(sub_read_data & a0[15:8], a0[7:0]);
    end
  end

  // Pulse counters, sampled mid-cycle so the launching edge cannot race them
  always @(negedge core_clk)
  begin
    n_subw += attr_write.we && !attr_write.host_side;
    n_res += uart_reset;
    if (uart_access.rd || uart_access.wr)
    begin
      n_acc++;
      lidx = uart_access.uart_register_index;
    end
    if (rx_fifo_push)
      chk(rx_fifo_data, pq.size() ? pq.pop_front() : 8'hxx);
  end

  // Low width and period of the divided clock, measured at each rise
  always @(negedge core_clk)
  begin
    per_c++;
    if (!uart_clock_output)
      lo_c++;
    else if (lo_c)
    begin
      lo_w = lo_c;
      per_w = per_c;
      lo_c = 0;
      per_c = 0;
    end
  end

  initial
  begin
    w(20000);
    fails++;
    end_of_test;
  end

  initial
  begin
    w(4);
    rst = 1'b0;
    w(2);
    chk({host_status_change_n, sub_interrupt, host_ready_interrupt_line}, 8'h04);
    chk({serial_bypass, uart_clock_output}, 8'h01);
    r(9'h110, 8'h22, 8'hff);
    r(9'h1ff, 8'h00, 8'hff);
    r(9'h132, 8'h36, 8'h36);
    $display("reset test done");
    h(10'h020, 8'h5a, aw);
    w(26);
    chk(sub_interrupt, 1'b1);
    s(9'h110, 8'h22, sw);
    w(26);
    chk(sub_interrupt, 1'b1);
    s(9'h110, 8'h62, sw);
    w(26);
    chk(sub_interrupt, 1'b0);
    r(9'h110, 8'h22, 8'hff);
    s(9'h010, 8'h11, sw);
    w(26);
    chk(host_status_change_n, 1'b1);
    s(9'h110, 8'h26, sw);
    s(9'h010, 8'h11, sw);
    w(26);
    chk(host_status_change_n, 1'b0);
    h(10'h000, 8'h00, ar);
    w(26);
    chk(host_status_change_n, 1'b1);
    fork
      s(9'h011, 8'h22, sw);
      h(10'h000, 8'h00, ar);
    join
    w(26);
    chk(host_status_change_n, 1'b0);
    h(10'h000, 8'h00, ar);
    w(26);
    chk(host_status_change_n, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      a0 = n_subw;
      fork
        s(9'h030 + 9'(i), 8'h33, sw);
        h(10'h060, 8'h44, aw);
      join
      w(4);
      chk(8'(n_subw - a0), 8'(i));
    end
    $display("handshake test done");
    ce = 3'b010;
    h(10'h3fa, 8'h30, iow);
    chk(8'(n_acc), 8'h00);
    s(9'h110, 8'h32, sw);
    w(2);
    chk(host_ready_interrupt_line, 1'b1);
    s(9'h110, 8'h12, sw);
    uart_interrupt = 1'b1;
    w(4);
    chk(host_ready_interrupt_line, 1'b1);
    uart_interrupt = 1'b0;
    w(4);
    chk(host_ready_interrupt_line, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      ce = (i == 0) ? 3'b010 : (i == 1) ? 3'b100 : 3'b011;
      a0 = n_acc;
      h(10'h005, 8'h00, ior);
      chk(8'(n_acc - a0), (i < 2) ? 8'h01 : 8'h00);
    end
    ce = 3'b010;
    for (int i = 0; i < 4; i++)
    begin
      h(10'h002, {2'(i), 6'h30}, iow);
      chk(fifo_mode, {2'b11, trig[i]});
    end
    r(9'h132, 8'h06, 8'h36);
    extend = 1'b1;
    w(6);
    chk(fifo_mode, 8'h0e);
    r(9'h132, 8'h36, 8'h36);
    extend = 1'b0;
    h(10'h004, 8'hff, iow);
    r(9'h134, 8'h1f, 8'h3f);
    s(9'h130, 8'h20, sw);
    h(10'h004, 8'h00, iow);
    chk(auto_cts_enable, 1'b1);
    r(9'h134, 8'h20, 8'h3f);
    ce = 3'h7;
    for (int i = 0; i < 4; i++)
    begin
      s(9'h110, {6'h06, com[i]}, sw);
      idx = 3'($random(seed));
      a0 = n_acc;
      h(base[i] | {7'h0, idx}, 8'h00, ior);
      h(base[i] ^ 10'h100, 8'h00, iow);
      chk(8'(n_acc - a0), 8'h01);
      chk(lidx, idx);
    end
    $display("uart select test done");
    foreach (dv[i])
    begin
      a0 = n_res;
      s(9'h120, {2'h0, dv[i]}, sw);
      lo_w = 0;
      w(dv[i] * 12 + 40);
      lo = (dv[i] < 4) ? 4 : (((dv[i] < 16) ? 2 : 8) + dv[i][0]) * 4;
      per = (dv[i] < 4) ? 8 : dv[i] * 4;
      chk(8'(n_res - a0), 8'h01);
      if (dv[i] == 0)
        chk({7'h0, !uart_clock_output} | 8'(lo_w), 8'h00);
      else
      begin
        chk(8'(lo_w), 8'(lo));
        chk(8'(per_w), 8'(per));
      end
    end
    $display("divider test done");
    s(9'h140, 8'h5a, sw);
    s(9'h110, 8'h92, sw);
    chk(serial_bypass, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      d = 8'($random(seed));
      pq.push_back(d);
      s(9'h140, d, sw);
      r(9'h140, 8'hc0 + 8'(i), 8'hff);
    end
    rst = 1'b1;
    w(4);
    rst = 1'b0;
    w(2);
    chk(serial_bypass, 1'b0);
    r(9'h110, 8'h22, 8'hff);
    $display("bypass test done");
    end_of_test;
  end
endmodule // pc_card_uart_glue_control_test
